/* verilog/sqsra_pkg.sv */
// Package for the queued serial port status and RAM access block.
package sqsra_pkg;
  // Register byte offsets on the Avalon-MM bus.
  localparam logic [11:0] SQSRA_OFF_IRQ_CTRL  = 12'h40c;
  localparam logic [11:0] SQSRA_OFF_ADDR_PTR  = 12'h410;
  localparam logic [11:0] SQSRA_OFF_DATA_WIN  = 12'h414;
  localparam logic [11:0] SQSRA_OFF_DELAY     = 12'h404;
  localparam logic [11:0] SQSRA_OFF_WRAP      = 12'h408;
  // Interrupt and error control, delay and wrap register field positions.
  localparam int SQSRA_B_COLL_ERR_EN   = 15;
  localparam int SQSRA_B_ABORT_ERR_EN  = 14;
  localparam int SQSRA_B_ABORT_LOCK    = 12;
  localparam int SQSRA_B_COLL_IRQ_EN   = 11;
  localparam int SQSRA_B_ABORT_IRQ_EN  = 10;
  localparam int SQSRA_B_FIN_IRQ_EN    = 8;
  localparam int SQSRA_B_COLL_FLAG     = 3;
  localparam int SQSRA_B_ABORT_FLAG    = 2;
  localparam int SQSRA_B_FIN_FLAG      = 0;
  localparam int SQSRA_B_QUEUE_EN      = 15;
  localparam int SQSRA_B_HALT          = 15;
  localparam int SQSRA_B_WRAP_EN       = 14;
  // Writable control bits of the interrupt register.
  localparam logic [15:0] SQSRA_IRQ_CTRL_MASK = 16'hdd00;
  // RAM layout: 48 entries, three sections of 16.
  localparam int SQSRA_RAM_DEPTH = 48;
  localparam logic [5:0] SQSRA_CMD_BASE = 6'h20;
  localparam logic [15:0] SQSRA_DATA_WIN_RST = 16'h0000;
  localparam logic [15:0] SQSRA_RST16 = 16'h0000;

  typedef enum logic [1:0] {
    SQSRA_IDLE = 2'b00,
    SQSRA_RD   = 2'b01,
    SQSRA_RESP = 2'b10
  } sqsra_bus_t;

  // Events coming in from the serial shift engine.
  typedef struct packed {
    logic       cmd_done;   // One-cycle pulse: current command completed.
    logic [3:0] exec_ptr;   // Entry now being executed.
    logic       busy;       // Transfer in progress.
  } sqsra_engine_t;

  typedef struct packed {
    sqsra_bus_t  bus;
    logic        wait_n;
    logic        resp_err;
    logic [31:0] rdata;
    logic [15:0] irq_ctrl;
    logic [2:0]  flags;      // collision, abort, finished
    logic [15:0] delay;
    logic [15:0] wrap;
    logic [5:0]  addr_ptr;
    logic [15:0] data_win;
    logic        irq;
  } sqsra_state_t;
endpackage

/* verilog/sqsra_top.sv */
// Status, error control and indirect RAM access of a queued serial port.
// Behaviour
// R1 - Collision error enable: data window write to executing command entry gives bus error.
// R2 - Abort error enable: clearing queue enable during transfer gives bus error.
// R3 - Abort lockout: CPU cannot clear queue enable; only completion clears it.
// R4 - Separate enables gate collision, abort and finished interrupts.
// R5 - Collision flag sets on write to executing entry; write one clears.
// R6 - Abort flag sets when CPU write clears queue enable during transfer; write one clears.
// R7 - Finished flag sets at end-of-queue completion or completion after halt.
// R8 - In wraparound mode finished flag sets at every end-of-queue completion.
// R9 - RAM holds 48 entries: 16 transmit, 16 receive, 16 command.
// R10 - Data window write stores at address pointer then increments pointer.
// R11 - Data window read returns entry at pointer then increments pointer.
// R12 - Data window read inserts exactly one wait state.
// R13 - Address pointer does not wrap at section boundaries.
// R14 - Data window is 16-bit read/write at 0x414, reset zero.
// R15 - Queue enable starts execution; port clears it when transfer completes.
// R16 - Halt request stops execution after current command finishes.
// R17 - Command entries written only via upper byte; port never changes them.
// R18 - Interrupt output high while any flag and its enable are set.
// R19 - Software writes zero to reserved interrupt register bits.
`timescale 1ns/1ps
`default_nettype none
module sqsra_top
  import sqsra_pkg::*;
(
  input  wire logic        clk,                // System clock, 125 MHz.
  input  wire logic        rst,                // Synchronous reset, active high.
  input  wire logic [11:0] avs_address,        // Byte address.
  input  wire logic        avs_read,           // Read request.
  input  wire logic        avs_write,          // Write request.
  input  wire logic [31:0] avs_writedata,      // Write data.
  input  wire logic [3:0]  avs_byteenable,     // Byte lanes.
  output logic [31:0]      avs_readdata,       // Read data.
  output logic             avs_waitrequest,    // Stall.
  output logic [1:0]       avs_response,       // 00 okay, 10 slave error.
  input  wire logic        eng_cmd_done,       // Engine: command completed pulse.
  input  wire logic [3:0]  eng_exec_ptr,       // Engine: executing entry.
  input  wire logic        eng_busy,           // Engine: transfer in progress.
  output logic             queue_enable,       // Run request to the engine.
  output logic             halt_req,           // Halt request to the engine.
  output logic [3:0]       end_of_queue_pointer, // Last entry of the queue.
  output logic             irq                 // Level interrupt.
);
  sqsra_state_t s_r, s_nxt;
  sqsra_engine_t eng;
  logic [15:0] ram_r [SQSRA_RAM_DEPTH];  // R9
  logic [15:0] wr_val;
  logic        ram_we;
  logic        hit_irq, hit_ptr, hit_win, hit_dly, hit_wrap;
  logic        is_cmd, coll, end_hit, fin_set;
  logic [15:0] rd_word;

  assign eng = '{cmd_done: eng_cmd_done, exec_ptr: eng_exec_ptr, busy: eng_busy};

  always_comb begin
    s_nxt    = s_r;
    ram_we   = 1'b0;
    wr_val   = avs_writedata[15:0];
    hit_irq  = avs_address == SQSRA_OFF_IRQ_CTRL;
    hit_ptr  = avs_address == SQSRA_OFF_ADDR_PTR;
    hit_win  = avs_address == SQSRA_OFF_DATA_WIN;
    hit_dly  = avs_address == SQSRA_OFF_DELAY;
    hit_wrap = avs_address == SQSRA_OFF_WRAP;
    // Pointers past the last command entry select no entry, so they never collide.
    is_cmd   = (s_r.addr_ptr >= SQSRA_CMD_BASE) && (s_r.addr_ptr < 6'(SQSRA_RAM_DEPTH));
    coll     = eng.busy && is_cmd && (s_r.addr_ptr[3:0] == eng.exec_ptr);
    end_hit  = eng.exec_ptr == s_r.wrap[11:8];
    fin_set  = eng.cmd_done && (end_hit || s_r.wrap[SQSRA_B_HALT]);
    rd_word  = (s_r.addr_ptr < 6'(SQSRA_RAM_DEPTH)) ? ram_r[s_r.addr_ptr] : SQSRA_RST16;
    // Completion events from the engine.
    if (fin_set) begin
      s_nxt.flags[0] = 1'b1;                               // R7 R8
      if (!s_r.wrap[SQSRA_B_WRAP_EN] || s_r.wrap[SQSRA_B_HALT]) begin
        s_nxt.delay[SQSRA_B_QUEUE_EN] = 1'b0;              // R15 R16
      end
    end
    case (s_r.bus)
      SQSRA_IDLE: begin
        s_nxt.resp_err = 1'b0;
        if (avs_write) begin
          s_nxt.bus    = SQSRA_RESP;
          s_nxt.wait_n = 1'b1;
          if (hit_irq) begin
            // Write one clears a flag; the set above is kept when both coincide.
            s_nxt.irq_ctrl = avs_writedata[15:0] & SQSRA_IRQ_CTRL_MASK;   // R4
            if (avs_writedata[SQSRA_B_COLL_FLAG]) begin
              s_nxt.flags[2] = 1'b0;                       // R5
            end
            if (avs_writedata[SQSRA_B_ABORT_FLAG]) begin
              s_nxt.flags[1] = 1'b0;                       // R6
            end
            if (avs_writedata[SQSRA_B_FIN_FLAG] && !fin_set) begin
              s_nxt.flags[0] = 1'b0;                       // R7
            end
          end else if (hit_ptr) begin
            s_nxt.addr_ptr = avs_writedata[5:0];
          end else if (hit_win) begin
            if (coll) begin
              s_nxt.flags[2] = 1'b1;                       // R5
            end
            if (coll && s_r.irq_ctrl[SQSRA_B_COLL_ERR_EN]) begin
              s_nxt.resp_err = 1'b1;                       // R1
            end else begin
              ram_we = s_r.addr_ptr < 6'(SQSRA_RAM_DEPTH);
              // Command entries take only the upper byte.
              if (is_cmd) begin
                wr_val = {avs_writedata[15:8], 8'h00};     // R17
              end
              s_nxt.data_win = wr_val;                     // R14
              s_nxt.addr_ptr = s_r.addr_ptr + 6'h01;       // R10 R13
            end
          end else if (hit_dly) begin
            if (!avs_writedata[SQSRA_B_QUEUE_EN] && s_r.delay[SQSRA_B_QUEUE_EN]) begin
              if (s_r.irq_ctrl[SQSRA_B_ABORT_LOCK]) begin
                // A completion in this same cycle still clears the enable.
                s_nxt.delay = {s_nxt.delay[SQSRA_B_QUEUE_EN], avs_writedata[14:0]}; // R3
              end else if (eng.busy && s_r.irq_ctrl[SQSRA_B_ABORT_ERR_EN]) begin
                s_nxt.resp_err = 1'b1;                     // R2
              end else begin
                s_nxt.delay    = avs_writedata[15:0];
                if (eng.busy) begin
                  s_nxt.flags[1] = 1'b1;                   // R6
                end
              end
            end else begin
              s_nxt.delay = avs_writedata[15:0];           // R15
            end
          end else if (hit_wrap) begin
            s_nxt.wrap = {avs_writedata[15:8], s_r.wrap[7:4], avs_writedata[3:0]};
          end
        end else if (avs_read) begin
          s_nxt.wait_n = 1'b0;
          if (hit_win) begin
            s_nxt.bus = SQSRA_RD;                          // R12
          end else begin
            s_nxt.bus    = SQSRA_RESP;
            s_nxt.wait_n = 1'b1;
            s_nxt.rdata  = 32'h0000_0000;
            if (hit_irq) begin
              s_nxt.rdata[15:0] = s_r.irq_ctrl
                                | {12'h000, s_r.flags[2], s_r.flags[1], 1'b0, s_r.flags[0]};
            end
            if (hit_ptr) s_nxt.rdata[5:0] = s_r.addr_ptr;
            if (hit_dly) s_nxt.rdata[15:0] = s_r.delay;
            if (hit_wrap) s_nxt.rdata[15:0] = {s_r.wrap[15:8], eng.exec_ptr, s_r.wrap[3:0]};
          end
        end
      end
      SQSRA_RD: begin
        s_nxt.bus      = SQSRA_RESP;
        s_nxt.wait_n   = 1'b1;
        s_nxt.data_win = rd_word;
        s_nxt.rdata    = {16'h0000, rd_word};              // R11
        s_nxt.addr_ptr = s_r.addr_ptr + 6'h01;             // R11 R13
      end
      SQSRA_RESP: begin
        s_nxt.bus    = SQSRA_IDLE;
        s_nxt.wait_n = 1'b0;
      end
      default: begin
        s_nxt.bus = SQSRA_IDLE;
      end
    endcase
    // Flags bit 2 is collision, bit 1 abort and bit 0 finished.
    s_nxt.irq = (s_nxt.flags[0] && s_nxt.irq_ctrl[SQSRA_B_FIN_IRQ_EN])
             || (s_nxt.flags[1] && s_nxt.irq_ctrl[SQSRA_B_ABORT_IRQ_EN])
             || (s_nxt.flags[2] && s_nxt.irq_ctrl[SQSRA_B_COLL_IRQ_EN]);   // R18
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{bus: SQSRA_IDLE, wait_n: 1'b0, resp_err: 1'b0, rdata: 32'h0000_0000,
               irq_ctrl: SQSRA_RST16, flags: 3'h0, delay: SQSRA_RST16, wrap: SQSRA_RST16,
               addr_ptr: 6'h00, data_win: SQSRA_DATA_WIN_RST, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // RAM content is not reset, matching an undefined power-up state.
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_r[s_r.addr_ptr] <= wr_val;
    end
  end

  always_comb begin
    avs_readdata         = s_r.rdata;
    avs_waitrequest      = !s_r.wait_n;
    avs_response         = s_r.resp_err ? 2'b10 : 2'b00;
    queue_enable         = s_r.delay[SQSRA_B_QUEUE_EN];
    halt_req             = s_r.wrap[SQSRA_B_HALT];
    end_of_queue_pointer = s_r.wrap[11:8];
    irq                  = s_r.irq;
  end
endmodule
`default_nettype wire

/* bench/sqsra_top_monitor.sv */
// Concurrent checks on the bus and control ports of the status and RAM access block.
`timescale 1ns/1ps
`default_nettype none
module sqsra_top_monitor
  import sqsra_pkg::*;
(
  input wire logic        clk,                  // Clock.
  input wire logic        rst,                  // Reset.
  input wire logic [11:0] avs_address,          // Address.
  input wire logic        avs_read,             // Read.
  input wire logic        avs_write,            // Write.
  input wire logic        avs_waitrequest,      // Stall.
  input wire logic        eng_cmd_done,         // Done pulse.
  input wire logic        queue_enable,         // Run.
  input wire logic        halt_req,             // Halt.
  input wire logic [3:0]  end_of_queue_pointer, // Last entry.
  input wire logic        irq                   // Interrupt.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_win_take;
    $rose(avs_read) && avs_address == SQSRA_OFF_DATA_WIN;
  endsequence
  sequence s_extra_wait;
    avs_waitrequest [*2] ##1 !avs_waitrequest;
  endsequence
  a_win_rd_wait: assert property (s_win_take |-> s_extra_wait)
    else $error("window read answer not after one wait state");
  a_wr_answer: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write answer timing wrong");
  a_ans_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer cycle longer than one");
  a_qen_start: assert property ($rose(queue_enable) |-> $past(avs_write))
    else $error("queue enable rose without a write");
  a_qen_clear: assert property ($fell(queue_enable) |-> $past(eng_cmd_done) || $past(avs_write))
    else $error("queue enable fell without cause");
  a_wrap_hold: assert property ($changed({halt_req, end_of_queue_pointer}) |->
    $past(avs_write && avs_address == SQSRA_OFF_WRAP))
    else $error("wrap outputs changed without a write");
  a_irq_rise: assert property ($rose(irq) |->
    $past(eng_cmd_done) || $past(eng_cmd_done, 2) || $past(avs_write))
    else $error("interrupt rose without an event");
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt fell without a write");
endmodule
bind sqsra_top sqsra_top_monitor u_mon (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .eng_cmd_done(eng_cmd_done), .queue_enable(queue_enable), .halt_req(halt_req),
  .end_of_queue_pointer(end_of_queue_pointer), .irq(irq));
`default_nettype wire

/* bench/sqsra_engine.sv */
// Behavioural model of the serial shift engine behind the block.
`timescale 1ns/1ps
`default_nettype none
module sqsra_engine (
  input  wire logic       clk,          // Clock.
  input  wire logic       rst,          // Reset.
  input  wire logic       queue_enable, // Run request.
  input  wire logic       hold,         // Stalls the current command.
  input  wire logic [3:0] eoq,          // Last entry.
  output var  logic       cmd_done,     // Done pulse.
  output var  logic [3:0] exec_ptr,     // Executing entry.
  output var  logic       busy          // Transfer in progress.
);
  always_ff @(posedge clk) begin
    cmd_done <= 1'b0;
    if (rst || !queue_enable) begin
      busy     <= 1'b0;
      exec_ptr <= 4'h0;
    end else begin
      busy <= 1'b1;
      if (cmd_done) begin
        exec_ptr <= (exec_ptr == eoq) ? 4'h0 : exec_ptr + 4'h1;
      end else if (busy && !hold) begin
        cmd_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench: register accesses against a small engine model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sqsra_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        hold = 1'b0;
  logic [31:0] rdata, got;
  logic [1:0]  resp;
  logic        stall, done, busy, qen, halt, irq;
  logic [3:0]  xptr, eoq;
  int          n_mismatch = 0;
  int          checked = 0;
  initial forever #4 clk = ~clk;
  sqsra_top u_sqsra_top (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(stall), .avs_response(resp), .eng_cmd_done(done), .eng_exec_ptr(xptr),
    .eng_busy(busy), .queue_enable(qen), .halt_req(halt), .end_of_queue_pointer(eoq), .irq(irq));
  sqsra_engine u_sqsra_engine (.clk(clk), .rst(rst), .queue_enable(qen), .hold(hold),
    .eoq(eoq), .cmd_done(done), .exec_ptr(xptr), .busy(busy));
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // The request stands until waitrequest is seen low at a rising edge; the answer is taken there.
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] er);
    int i;
    i = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {16'h0, d};
    @(posedge clk);
    while (stall !== 1'b0 && i < 20) begin
      @(posedge clk);
      i++;
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (stall !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
    chk({30'h0, resp}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic wait_irq();
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 50) begin
      @(posedge clk);
      i++;
    end
    if (irq !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic ctl_rd(input logic [31:0] e);
    bus(1'b0, SQSRA_OFF_IRQ_CTRL, 16'h0, 2'b00);
    chk(got, e);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 12'h000, 16'h0, 2'b00); chk(got, 32'h0);
    bus(1'b1, SQSRA_OFF_ADDR_PTR, 16'h000e, 2'b00);
    for (int k = 0; k < 4; k++) bus(1'b1, SQSRA_OFF_DATA_WIN, 16'ha5c0 + k[15:0], 2'b00);
    bus(1'b1, SQSRA_OFF_ADDR_PTR, 16'h002f, 2'b00);
    bus(1'b1, SQSRA_OFF_DATA_WIN, 16'h1234, 2'b00);
    bus(1'b1, SQSRA_OFF_ADDR_PTR, 16'h000e, 2'b00);
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, SQSRA_OFF_DATA_WIN, 16'h0, 2'b00);
      chk(got, {16'h0, 16'ha5c0 + k[15:0]});
    end
    bus(1'b0, SQSRA_OFF_ADDR_PTR, 16'h0, 2'b00); chk(got, 32'h12);
    bus(1'b1, SQSRA_OFF_ADDR_PTR, 16'h002f, 2'b00);
    bus(1'b0, SQSRA_OFF_DATA_WIN, 16'h0, 2'b00); chk(got, 32'h1200);
    bus(1'b1, SQSRA_OFF_WRAP, 16'h0100, 2'b00);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0100, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h8000, 2'b00);
    wait_irq();
    ctl_rd(32'h0101);
    chk({31'h0, qen}, 32'h0);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0101, 2'b00); chk({31'h0, irq}, 32'h0);
    hold <= 1'b1;
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h8800, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h8000, 2'b00);
    bus(1'b1, SQSRA_OFF_ADDR_PTR, 16'h0020, 2'b00);
    bus(1'b1, SQSRA_OFF_DATA_WIN, 16'hff00, 2'b10);
    ctl_rd(32'h8808);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, SQSRA_OFF_ADDR_PTR, 16'h0, 2'b00); chk(got, 32'h20);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h4c08, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h0000, 2'b10);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h1400, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h0000, 2'b00); chk({31'h0, qen}, 32'h1);
    ctl_rd(32'h1400);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0400, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h0000, 2'b00); chk({31'h0, irq}, 32'h1);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0000, 2'b00); chk({31'h0, irq}, 32'h0);
    ctl_rd(32'h0004);
    hold <= 1'b0;
    bus(1'b1, SQSRA_OFF_WRAP, 16'h4100, 2'b00);
    chk({28'h0, eoq}, 32'h1);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0105, 2'b00);
    bus(1'b1, SQSRA_OFF_DELAY, 16'h8000, 2'b00);
    wait_irq();
    chk({31'h0, qen}, 32'h1);
    bus(1'b1, SQSRA_OFF_IRQ_CTRL, 16'h0101, 2'b00);
    wait_irq();
    bus(1'b1, SQSRA_OFF_WRAP, 16'hc100, 2'b00);
    chk({31'h0, halt}, 32'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, qen}, 32'h0);
    ctl_rd(32'h0101);
    end_sim();
  end
endmodule
`default_nettype wire
